// File: dv/dlm_field.sv
// far-side model: safety circuit on the removal pair and the three switches
// assumes the bench steers it once per clock; outputs are registered
`timescale 1ns/100ps
module dlm_field (
	input wire logic clk_in,            // 10 MHz clock
	input wire logic trip_in,           // request safety disconnection
	input wire logic break_a_in,        // wire a of the pair broken
	input wire logic [2:0] pressed_in,  // switch actuated: 0 home, 1 neg, 2 pos
	input wire logic [2:0] high_act_in, // switch wired active high
	output logic power_removal_a_out,   // 1 = 24 V present
	output logic power_removal_b_out,   // 1 = 24 V present
	output logic [2:0] switch_out       // switch line levels
);
	// ----------------------------------------
	// pair and switch levels
	// ----------------------------------------
	// both lines fall on one edge, so a true trip never looks like a skew
	always_ff @(posedge clk_in) begin
		power_removal_a_out <= ~(trip_in | break_a_in);
		power_removal_b_out <= ~trip_in;
		// active low lines read as actuated when the wire breaks
		switch_out <= pressed_in ~^ high_act_in;
	end
endmodule : dlm_field

// File: dv/tb.sv
// self-checking bench of the drive i/o and limit monitor
// assumes dlm_top, dlm_field and dlm_pkg are compiled before it
`timescale 1ns/100ps
module tb;
	logic clk_in, reset_in, wr, rd, ack, cur_en, spd_en, amp_off, err, ffree, dact;
	logic cmd_loc, pos_pd, fb_mode, f_clr, en, alt, halt, pra, prb, trip, brk;
	logic [15:0] addr, wdata, rdata, panel, motor, amp, ceil, cur, spd, code, q;
	logic signed [15:0] mv;
	logic [2:0] sw, pressed;
	dlm_pkg::dlm_sw_cfg_type cfg;
	int mismatches, cmp_count;
	dlm_top #(.SKEW_CYC(4)) u_dlm_top (.clk_in(clk_in), .reset_in(reset_in),
		.param_addr_in(addr), .param_wr_in(wr), .param_rd_in(rd),
		.param_wdata_in(wdata), .param_rdata_out(rdata), .param_ack_out(ack),
		.panel_word_out(panel), .analog_two_in(mv), .motor_peak_in(motor),
		.amp_peak_in(amp), .speed_ceiling_in(ceil), .cmd_local_io_in(cmd_loc),
		.pos_if_pulse_dir_in(pos_pd), .fieldbus_mode_in(fb_mode), .sw_cfg_in(cfg),
		.switch_in(sw), .fault_clear_in(f_clr), .enable_in(en), .alt_enable_in(alt),
		.halt_in(halt), .power_removal_a_in(pra), .power_removal_b_in(prb),
		.current_limit_out(cur), .current_limit_en_out(cur_en),
		.speed_limit_out(spd), .speed_limit_en_out(spd_en), .amp_off_out(amp_off),
		.error_out(err), .error_code_out(code), .fault_free_out(ffree),
		.drive_active_out(dact));
	dlm_field u_dlm_field (.clk_in(clk_in), .trip_in(trip), .break_a_in(brk),
		.pressed_in(pressed), .high_act_in(cfg.high_act), .power_removal_a_out(pra),
		.power_removal_b_out(prb), .switch_out(sw));
	// ----------------------------------------
	// clock, reset, watchdog
	// ----------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	// the whole run needs about 150 cycles; 20000 is a hang
	initial begin
		repeat (20000) @(posedge clk_in);
		mismatches++;
		close_out();
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one strobe, then wait for the ack pulse under a bound
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		int n;
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= ~w;
		@(posedge clk_in);
		wr <= 1'b0;
		rd <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (ack !== 1'b1 && n < 8);
		if (n >= 8) mismatches++;
		q = rdata;
	endtask : acc
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		acc(1'b0, a, 16'h0000);
		chk(q, exp);
	endtask : rd_chk
	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
	endtask : settle
	task automatic clear_faults();
		f_clr <= 1'b1;
		settle(3);
		f_clr <= 1'b0;
		settle(2);
	endtask : clear_faults
	task automatic close_out();
		$display("counts: comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		rd_chk(16'h1216, 16'h0000);
		rd_chk(16'h1218, 16'h012C);
		rd_chk(16'h121A, 16'h0BB8);
		rd_chk(16'h1234, 16'h0000);
		acc(1'b1, 16'h1218, 16'hFFFF);
		rd_chk(16'h1218, 16'h7530);
		acc(1'b1, 16'h1218, 16'h012C);
		acc(1'b1, 16'h0802, 16'hFFFF);
		rd_chk(16'h0802, 16'h0130);
		acc(1'b1, 16'h1216, 16'h0002);
		acc(1'b1, 16'h1216, 16'h0003);
		rd_chk(16'h1216, 16'h0002);
		acc(1'b1, 16'h121A, 16'h0064);
		rd_chk(16'h121A, 16'h01F4);
		acc(1'b1, 16'h121A, 16'h0BB8);
		$display("test regs done");
	endtask : t_regs
	task automatic t_current();
		acc(1'b1, 16'h1216, 16'h0001);
		mv <= 16'sd5000;
		settle(3);
		chk(cur, 16'd150);
		chk({15'h0, cur_en}, 16'h0001);
		chk({15'h0, spd_en}, 16'h0000);
		motor <= 16'd100;
		settle(3);
		chk(cur, 16'd100);
		motor <= 16'hFFFF;
		amp <= 16'd120;
		settle(3);
		chk(cur, 16'd120);
		mv <= -16'sd1000;
		settle(3);
		chk(cur, 16'd0);
		acc(1'b1, 16'h1216, 16'h0000);
		settle(2);
		chk({14'h0, cur_en, spd_en}, 16'h0000);
		$display("test current done");
	endtask : t_current
	task automatic t_speed();
		acc(1'b1, 16'h1216, 16'h0002);
		mv <= 16'sd5000;
		settle(3);
		chk(spd, 16'd1500);
		chk({14'h0, cur_en, spd_en}, 16'h0001);
		ceil <= 16'd1000;
		settle(3);
		chk(spd, 16'd1000);
		mv <= 16'sd300;
		settle(3);
		chk({15'h0, spd_en}, 16'h0000);
		acc(1'b1, 16'h1216, 16'h0000);
		$display("test speed done");
	endtask : t_speed
	task automatic t_io();
		f_clr <= 1'b1;
		en <= 1'b1;
		alt <= 1'b1;
		halt <= 1'b1;
		settle(4);
		chk(panel, 16'h037E);
		chk({15'h0, dact}, 16'h0001);
		rd_chk(16'h0802, 16'h037E);
		pos_pd <= 1'b0;
		en <= 1'b0;
		settle(4);
		chk(panel, 16'h013A);
		chk({15'h0, dact}, 16'h0000);
		f_clr <= 1'b0;
		fb_mode <= 1'b1;
		pressed <= 3'b001;
		settle(4);
		chk(panel, 16'h0139);
		pressed <= 3'b000;
		fb_mode <= 1'b0;
		pos_pd <= 1'b1;
		cmd_loc <= 1'b0;
		settle(4);
		chk(panel, 16'h0138);
		chk({15'h0, dact}, 16'h0000);
		cmd_loc <= 1'b1;
		settle(3);
		$display("test io done");
	endtask : t_io
	task automatic t_switches();
		pressed <= 3'b100;
		settle(4);
		chk({14'h0, err, ffree}, 16'h0002);
		chk(code, 16'h0A01);
		pressed <= 3'b000;
		clear_faults();
		cfg.enable <= 3'b011;
		pressed <= 3'b100;
		settle(4);
		chk({15'h0, err}, 16'h0000);
		pressed <= 3'b010;
		cfg.high_act <= 3'b010;
		settle(4);
		chk(code, 16'h0A02);
		pressed <= 3'b000;
		clear_faults();
		chk({15'h0, err}, 16'h0000);
		$display("test switches done");
	endtask : t_switches
	task automatic t_removal();
		trip <= 1'b1;
		settle(4);
		chk({15'h0, amp_off}, 16'h0001);
		chk(code, 16'h0514);
		trip <= 1'b0;
		settle(4);
		chk({15'h0, amp_off}, 16'h0001);
		clear_faults();
		chk({15'h0, amp_off}, 16'h0000);
		brk <= 1'b1;
		settle(3);
		chk({15'h0, amp_off}, 16'h0001);
		chk(code, 16'h0000);
		settle(8);
		chk(code, 16'h0515);
		brk <= 1'b0;
		clear_faults();
		chk(code, 16'h0000);
		$display("test removal done");
	endtask : t_removal
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		mismatches = 0;
		cmp_count = 0;
		reset_in = 1'b1;
		{wr, rd, fb_mode, f_clr, en, alt, halt, trip, brk} = '0;
		{cmd_loc, pos_pd} = 2'b11;
		addr = 16'h0000;
		wdata = 16'h0000;
		mv = 16'sd0;
		motor = 16'hFFFF;
		amp = 16'hFFFF;
		ceil = 16'd30000;
		pressed = 3'b000;
		cfg = '{enable: 3'b111, high_act: 3'b000};
		settle(12);
		reset_in <= 1'b0;
		settle(1);
		t_regs();
		t_current();
		t_speed();
		t_io();
		t_switches();
		t_removal();
		close_out();
	end
endmodule : tb

// File: src/dlm_defs.svh
// constants of the drive i/o and limit monitor: addresses, reset values, codes
// assumes one 10 MHz clock; included by bare name
// Notes on behaviour
// RQ1: mode 0 none, 1 current, 2 speed
// RQ2: full scale at 10 V from selected register
// RQ3: current limit capped by motor and amplifier peak
// RQ4: speed limit below 100 rpm has no effect
// RQ5: speed limit also bounded by speed ceiling
// RQ6: input states packed in bits 0 to 7
// RQ7: bit 6 enables only in local pulse/direction
// RQ8: bits read 1 active; bits 8, 9 outputs
// RQ9: panel may only show the i/o word
// RQ10: both removal inputs off: amplifier off, 1300
// RQ11: removal pair wiring fault reports 1301
// RQ12: safety circuit drops both inputs together
// RQ13: enabled active limit switch raises error
// RQ14: per switch enable and polarity select
// RQ15: integrator prefers active low monitoring inputs
// RQ16: linear 0..10 V scaling, never negative
`ifndef DLM_DEFS_SVH
`define DLM_DEFS_SVH
// ----------------------------------------
// parameter addresses
// ----------------------------------------
`define DLM_ADDR_IO_STATE 16'h0802
`define DLM_ADDR_LIM_SEL 16'h1216
`define DLM_ADDR_CUR_FS 16'h1218
`define DLM_ADDR_SPD_FS 16'h121A
// ----------------------------------------
// reset values and ranges
// ----------------------------------------
`define DLM_RST_LIM_SEL 16'h0000
`define DLM_RST_CUR_FS 16'h012C
`define DLM_RST_SPD_FS 16'h0BB8
`define DLM_LIM_SEL_MAX 16'h0002
`define DLM_CUR_FS_MAX 16'h7530
`define DLM_SPD_FS_MIN 16'h01F4
`define DLM_SPD_FS_MAX 16'h7530
`define DLM_SPD_FLOOR 16'h0064
`define DLM_FULL_MV 32'h0000_2710
// ----------------------------------------
// error codes
// ----------------------------------------
`define DLM_ERR_NONE 16'h0000
`define DLM_ERR_PWR_OFF 16'h0514
`define DLM_ERR_PWR_WIRE 16'h0515
`define DLM_ERR_LIM_POS 16'h0A01
`define DLM_ERR_LIM_NEG 16'h0A02
// ----------------------------------------
// timing
// ----------------------------------------
`define DLM_CLK_NS 32'h0000_0064
`define DLM_PR_SKEW_NS 32'h0000_2710
// ----------------------------------------
// io word bit positions
// ----------------------------------------
`define DLM_BIT_FAULT_CLR 1
`define DLM_BIT_ENABLE 2
`define DLM_BIT_HALT 3
`define DLM_BIT_PWR_B 4
`define DLM_BIT_PWR_A 5
`define DLM_BIT_ALT_EN 6
`define DLM_BIT_FAULT_FREE 8
`define DLM_BIT_ACTIVE 9
`endif

// File: src/dlm_pkg.sv
// types of the drive i/o and limit monitor
// stands alone; its encodings are local and none come from dlm_defs.svh
package dlm_pkg;
	// limit source, gray along none-current-speed
	typedef enum logic [1:0] {
		DLM_LIM_NONE = 2'b00,
		DLM_LIM_CURR = 2'b01,
		DLM_LIM_SPED = 2'b11
	} dlm_lim_type;
	// power removal supervision states
	typedef enum logic [1:0] {
		DLM_PR_OK = 2'b00,
		DLM_PR_SKEW = 2'b01,
		DLM_PR_OFF = 2'b11,
		DLM_PR_WIRE = 2'b10
	} dlm_pr_type;
	// limit switch settings, one bit per switch: 0 home, 1 neg, 2 pos
	typedef struct packed {
		logic [2:0] enable;   // switch monitored
		logic [2:0] high_act; // 1 active high, 0 active low
	} dlm_sw_cfg_type;
	// whole state of the top module
	typedef struct packed {
		dlm_lim_type lim_sel;
		logic [15:0] cur_fs;
		logic [15:0] spd_fs;
		logic [15:0] io_word;
		logic [15:0] rdata;
		logic ack;
		logic [15:0] cur_lim;
		logic cur_en;
		logic [15:0] spd_lim;
		logic spd_en;
		dlm_pr_type pr_state;
		logic [15:0] skew_cnt;
		logic err_active;
		logic [15:0] err_code;
		logic drive_active;
	} dlm_state_type;
endpackage : dlm_pkg

// File: src/dlm_scale.sv
// linear scaler: full scale value times input millivolts over 10 V
// assumes the input is a signed millivolt sample; result is combinational
`timescale 1ns/100ps
`include "dlm_defs.svh"
module dlm_scale #(
	parameter int WIDTH = 16 // value width
) (
	input wire logic [WIDTH-1:0] full_in,   // value at 10 V
	input wire logic signed [15:0] mv_in,   // analog sample in mV
	output logic [WIDTH-1:0] value_out      // scaled, never negative
);
	logic [47:0] prod; // wide enough for 16x16 before divide
	// ----------------------------------------
	// scaling
	// ----------------------------------------
	// clamped at both ends so a noisy input cannot wrap the product
	always_comb begin
		prod = 48'(full_in) * 48'(mv_in[14:0]);
		if (mv_in[15]) begin
			value_out = '0; // negative input gives no limit value [RQ16]
		end else if (32'(mv_in) >= `DLM_FULL_MV) begin
			value_out = full_in; // at or above 10 V [RQ2]
		end else begin
			value_out = WIDTH'(prod / 48'(`DLM_FULL_MV)); // linear [RQ16]
		end
	end
endmodule : dlm_scale

// File: src/dlm_top.sv
// drive i/o and limit monitor: analog limit, i/o status word, safety inputs
// assumes all pins synchronous to clk_in; parameters reached by address port
`timescale 1ns/100ps
`include "dlm_defs.svh"
module dlm_top #(
	parameter int SKEW_CYC = `DLM_PR_SKEW_NS / `DLM_CLK_NS // removal skew window
) (
	input wire logic clk_in,                      // 10 MHz clock
	input wire logic reset_in,                    // sync reset, active high
	input wire logic [15:0] param_addr_in,        // parameter address
	input wire logic param_wr_in,                 // write strobe
	input wire logic param_rd_in,                 // read strobe
	input wire logic [15:0] param_wdata_in,       // write data
	output logic [15:0] param_rdata_out,          // read data
	output logic param_ack_out,                   // access done pulse
	output logic [15:0] panel_word_out,           // i/o word for panel display
	input wire logic signed [15:0] analog_two_in, // analog input two, mV
	input wire logic [15:0] motor_peak_in,        // motor peak current, 0.01 A
	input wire logic [15:0] amp_peak_in,          // amplifier peak, 0.01 A
	input wire logic [15:0] speed_ceiling_in,     // speed ceiling, rpm
	input wire logic cmd_local_io_in,             // command source is local i/o
	input wire logic pos_if_pulse_dir_in,         // position i/f is pulse/dir
	input wire logic fieldbus_mode_in,            // fieldbus control mode
	input wire dlm_pkg::dlm_sw_cfg_type sw_cfg_in, // limit switch settings
	input wire logic [2:0] switch_in,             // raw: 0 home, 1 neg, 2 pos
	input wire logic fault_clear_in,              // fault clear input
	input wire logic enable_in,                   // enable input
	input wire logic alt_enable_in,               // alternate enable input
	input wire logic halt_in,                     // halt input
	input wire logic power_removal_a_in,          // 1 = 24 V present
	input wire logic power_removal_b_in,          // 1 = 24 V present
	output logic [15:0] current_limit_out,        // current limit, 0.01 A
	output logic current_limit_en_out,            // current limit applied
	output logic [15:0] speed_limit_out,          // speed limit, rpm
	output logic speed_limit_en_out,              // speed limit applied
	output logic amp_off_out,                     // power amplifier off
	output logic error_out,                       // error present
	output logic [15:0] error_code_out,           // error code
	output logic fault_free_out,                  // no fault output
	output logic drive_active_out                 // drive active output
);
	dlm_pkg::dlm_state_type s_reg; // all state
	dlm_pkg::dlm_state_type s_next; // next state
	logic [2:0] sw_act; // switch active after polarity and enable
	logic [15:0] cur_scaled; // scaled current value
	logic [15:0] spd_scaled; // scaled speed value
	logic [15:0] peak_cap; // lesser of the two peaks
	logic alt_en_ok; // bit 6 acts as enable
	logic drive_en; // effective enable
	logic [15:0] io_word; // live i/o word

	// ----------------------------------------
	// limit switch evaluation
	// ----------------------------------------
	// active low is wire-break safe, chosen by the integrator [RQ15]
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sw
			assign sw_act[gi] = sw_cfg_in.enable[gi] &
				(sw_cfg_in.high_act[gi] ? switch_in[gi] : ~switch_in[gi]); // [RQ14]
		end
	endgenerate

	// ----------------------------------------
	// scalers
	// ----------------------------------------
	dlm_scale #(.WIDTH(16)) u_cur_scale (
		.full_in(s_reg.cur_fs),
		.mv_in(analog_two_in),
		.value_out(cur_scaled)
	);
	dlm_scale #(.WIDTH(16)) u_spd_scale (
		.full_in(s_reg.spd_fs),
		.mv_in(analog_two_in),
		.value_out(spd_scaled)
	);

	// ----------------------------------------
	// i/o word assembly
	// ----------------------------------------
	always_comb begin
		alt_en_ok = cmd_local_io_in & pos_if_pulse_dir_in; // [RQ7]
		drive_en = enable_in | (alt_en_ok & alt_enable_in);
		peak_cap = (motor_peak_in < amp_peak_in) ? motor_peak_in : amp_peak_in;
		io_word = '0; // unused and reserved bits read 0
		io_word[`DLM_BIT_FAULT_FREE] = ~s_reg.err_active; // [RQ8]
		io_word[`DLM_BIT_ACTIVE] = s_reg.drive_active; // [RQ8]
		io_word[`DLM_BIT_HALT] = halt_in; // [RQ6]
		io_word[`DLM_BIT_PWR_B] = power_removal_b_in; // [RQ6]
		io_word[`DLM_BIT_PWR_A] = power_removal_a_in; // [RQ6]
		if (fieldbus_mode_in) begin
			io_word[2:0] = {sw_act[2], sw_act[1], sw_act[0]}; // [RQ6]
		end else begin
			io_word[`DLM_BIT_FAULT_CLR] = fault_clear_in; // [RQ6]
			io_word[`DLM_BIT_ENABLE] = enable_in; // [RQ6]
			io_word[`DLM_BIT_ALT_EN] = alt_en_ok & alt_enable_in; // [RQ7]
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.io_word = io_word;
		s_next.ack = param_wr_in | param_rd_in;
		// parameter writes; the status word ignores them, so the panel and
		// the bus can only look at it [RQ9]
		if (param_wr_in) begin
			case (param_addr_in)
				`DLM_ADDR_LIM_SEL: begin
					if (param_wdata_in <= `DLM_LIM_SEL_MAX) begin
						// value 2 maps to the gray code of speed mode [RQ1]
						s_next.lim_sel = (param_wdata_in == `DLM_LIM_SEL_MAX) ?
							dlm_pkg::DLM_LIM_SPED : dlm_pkg::dlm_lim_type'(param_wdata_in[1:0]);
					end
				end
				`DLM_ADDR_CUR_FS: begin
					s_next.cur_fs = (param_wdata_in > `DLM_CUR_FS_MAX) ?
						`DLM_CUR_FS_MAX : param_wdata_in; // [RQ3]
				end
				`DLM_ADDR_SPD_FS: begin
					if (param_wdata_in < `DLM_SPD_FS_MIN) begin
						s_next.spd_fs = `DLM_SPD_FS_MIN;
					end else if (param_wdata_in > `DLM_SPD_FS_MAX) begin
						s_next.spd_fs = `DLM_SPD_FS_MAX;
					end else begin
						s_next.spd_fs = param_wdata_in;
					end
				end
				default: begin
					s_next.lim_sel = s_reg.lim_sel; // read-only or unmapped
				end
			endcase
		end
		// parameter reads, unmapped read 0
		case (param_addr_in)
			`DLM_ADDR_IO_STATE: s_next.rdata = s_reg.io_word;
			`DLM_ADDR_LIM_SEL: s_next.rdata = (s_reg.lim_sel == dlm_pkg::DLM_LIM_SPED) ?
				`DLM_LIM_SEL_MAX : {14'h0000, s_reg.lim_sel};
			`DLM_ADDR_CUR_FS: s_next.rdata = s_reg.cur_fs;
			`DLM_ADDR_SPD_FS: s_next.rdata = s_reg.spd_fs;
			default: s_next.rdata = '0;
		endcase
		if (!param_rd_in) begin
			s_next.rdata = s_reg.rdata; // hold last answer
		end
		// analog limit
		s_next.cur_en = (s_reg.lim_sel == dlm_pkg::DLM_LIM_CURR); // [RQ1]
		s_next.cur_lim = (cur_scaled < peak_cap) ? cur_scaled : peak_cap; // [RQ3]
		s_next.spd_lim = (spd_scaled < speed_ceiling_in) ? spd_scaled : speed_ceiling_in; // [RQ5]
		// below the floor the analog value does not limit at all
		s_next.spd_en = (s_reg.lim_sel == dlm_pkg::DLM_LIM_SPED) &&
			(spd_scaled >= `DLM_SPD_FLOOR) && (s_next.spd_lim >= `DLM_SPD_FLOOR); // [RQ4]
		// power removal supervision; a lone dropped input is given a short
		// window because the two contacts may not open in the same cycle [RQ12]
		case (s_reg.pr_state)
			dlm_pkg::DLM_PR_OK: begin
				s_next.skew_cnt = '0;
				if (!power_removal_a_in && !power_removal_b_in) begin
					s_next.pr_state = dlm_pkg::DLM_PR_OFF; // [RQ10]
				end else if (!power_removal_a_in || !power_removal_b_in) begin
					s_next.pr_state = dlm_pkg::DLM_PR_SKEW;
				end
			end
			dlm_pkg::DLM_PR_SKEW: begin
				s_next.skew_cnt = s_reg.skew_cnt + 16'h0001;
				if (!power_removal_a_in && !power_removal_b_in) begin
					s_next.pr_state = dlm_pkg::DLM_PR_OFF; // [RQ10]
				end else if (power_removal_a_in && power_removal_b_in) begin
					s_next.pr_state = dlm_pkg::DLM_PR_OK;
				end else if (s_reg.skew_cnt >= 16'(SKEW_CYC - 1)) begin
					s_next.pr_state = dlm_pkg::DLM_PR_WIRE; // [RQ11]
				end
			end
			dlm_pkg::DLM_PR_OFF, dlm_pkg::DLM_PR_WIRE: begin
				// leaves only by fault clear with both inputs back
				if (fault_clear_in && power_removal_a_in && power_removal_b_in) begin
					s_next.pr_state = dlm_pkg::DLM_PR_OK;
				end
			end
			default: s_next.pr_state = dlm_pkg::DLM_PR_OK;
		endcase
		// error latch: a new cause wins over a simultaneous clear
		if (fault_clear_in) begin
			s_next.err_active = 1'b0;
			s_next.err_code = `DLM_ERR_NONE;
		end
		if (sw_act[1]) begin
			s_next.err_active = 1'b1;
			s_next.err_code = `DLM_ERR_LIM_NEG; // [RQ13]
		end
		if (sw_act[2]) begin
			s_next.err_active = 1'b1;
			s_next.err_code = `DLM_ERR_LIM_POS; // [RQ13]
		end
		if (s_next.pr_state == dlm_pkg::DLM_PR_WIRE) begin
			s_next.err_active = 1'b1;
			s_next.err_code = `DLM_ERR_PWR_WIRE; // [RQ11]
		end
		if (s_next.pr_state == dlm_pkg::DLM_PR_OFF) begin
			s_next.err_active = 1'b1;
			s_next.err_code = `DLM_ERR_PWR_OFF; // [RQ10]
		end
		s_next.drive_active = drive_en & ~s_next.err_active &
			(s_next.pr_state == dlm_pkg::DLM_PR_OK);
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s_reg <= '0;
			s_reg.lim_sel <= dlm_pkg::DLM_LIM_NONE;
			s_reg.cur_fs <= `DLM_RST_CUR_FS;
			s_reg.spd_fs <= `DLM_RST_SPD_FS;
			s_reg.pr_state <= dlm_pkg::DLM_PR_OK;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign param_rdata_out = s_reg.rdata;
	assign param_ack_out = s_reg.ack;
	assign panel_word_out = s_reg.io_word; // display only [RQ9]
	assign current_limit_out = s_reg.cur_lim;
	assign current_limit_en_out = s_reg.cur_en;
	assign speed_limit_out = s_reg.spd_lim;
	assign speed_limit_en_out = s_reg.spd_en;
	assign amp_off_out = (s_reg.pr_state != dlm_pkg::DLM_PR_OK); // [RQ10]
	assign error_out = s_reg.err_active;
	assign error_code_out = s_reg.err_code;
	assign fault_free_out = ~s_reg.err_active; // [RQ8]
	assign drive_active_out = s_reg.drive_active; // [RQ8]

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_lim_none;
		@(posedge clk_in) disable iff (reset_in)
		(s_reg.lim_sel == dlm_pkg::DLM_LIM_NONE) |=> !current_limit_en_out && !speed_limit_en_out;
	endproperty
	a_lim_none: assert property (p_lim_none) else $error("limit applied in mode 0"); // [RQ1]
	property p_cur_cap;
		@(posedge clk_in) disable iff (reset_in)
		##1 (current_limit_out <= $past(motor_peak_in)) && (current_limit_out <= $past(amp_peak_in));
	endproperty
	a_cur_cap: assert property (p_cur_cap) else $error("current limit above peak"); // [RQ3]
	property p_spd_floor;
		@(posedge clk_in) disable iff (reset_in)
		speed_limit_en_out |-> speed_limit_out >= `DLM_SPD_FLOOR;
	endproperty
	a_spd_floor: assert property (p_spd_floor) else $error("speed limit under floor"); // [RQ4]
	property p_spd_ceil;
		@(posedge clk_in) disable iff (reset_in)
		##1 speed_limit_out <= $past(speed_ceiling_in);
	endproperty
	a_spd_ceil: assert property (p_spd_ceil) else $error("speed limit above ceiling"); // [RQ5]
	property p_pwr_off;
		@(posedge clk_in) disable iff (reset_in)
		(!power_removal_a_in && !power_removal_b_in && !amp_off_out)
			|=> amp_off_out && error_code_out == `DLM_ERR_PWR_OFF;
	endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("removal did not stop amplifier"); // [RQ10]
	property p_wire;
		@(posedge clk_in) disable iff (reset_in)
		$rose(s_reg.pr_state == dlm_pkg::DLM_PR_WIRE) |-> error_code_out == `DLM_ERR_PWR_WIRE
			&& $past(s_reg.pr_state) == dlm_pkg::DLM_PR_SKEW;
	endproperty
	a_wire: assert property (p_wire) else $error("wiring fault not reported"); // [RQ11]
	property p_bit6;
		@(posedge clk_in) disable iff (reset_in)
		!(cmd_local_io_in && pos_if_pulse_dir_in) |=> !panel_word_out[`DLM_BIT_ALT_EN];
	endproperty
	a_bit6: assert property (p_bit6) else $error("bit 6 set outside pulse mode"); // [RQ7]
	property p_limsw;
		@(posedge clk_in) disable iff (reset_in)
		(sw_act[2] || sw_act[1]) |=> error_out ##0 !fault_free_out;
	endproperty
	a_limsw: assert property (p_limsw) else $error("limit switch gave no error"); // [RQ13]
	property p_neg_in;
		@(posedge clk_in) disable iff (reset_in)
		analog_two_in[15] |=> current_limit_out == 16'h0000;
	endproperty
	a_neg_in: assert property (p_neg_in) else $error("negative input gave a limit"); // [RQ16]
endmodule : dlm_top
